// ===== logic/lds_i2c_slave.sv
// Serial slave port of the LED driver with register pointer and bus timeout
// Functional notes
// RULE1 - Registers return to defaults on power loss, disable or over-temperature
// RULE2 - Over-temperature keeps the port disabled and registers at defaults
// RULE3 - Host rewrites any non-default setting after every turn-on
// RULE4 - Driver runs fully on default registers without any serial access
// RULE5 - Master starts every transfer and makes the clock; device is slave
// RULE6 - Data line is input plus open-drain pull-low output
// RULE7 - Clock line is only an input, never stretched
// RULE8 - Transfer: START, address plus direction, ack, data bytes with acks, STOP
// RULE9 - With timeout enabled, either line low beyond 30 ms aborts, releases
// RULE10 - Transmitter keeps data stable while clock is high
// RULE11 - Data falling with clock high is START, rising is STOP
// RULE12 - Ninth clock is acknowledge; receiver pulls data low
// RULE13 - Only the fixed 7-bit address 0b1010000 is answered
// RULE14 - Direction bit 0 writes, 1 reads: bytes 0xa0 and 0xa1
// RULE15 - Works with bus clocks of 100 kHz, 400 kHz and 1 MHz
// RULE16 - Open-drain fault alert output for the host
// RULE17 - First write byte sets pointer; later bytes written, pointer increments
// RULE18 - Reads send from pointer, increment on master ack, end on nack
// RULE19 - Wrong address is not acknowledged; bus ignored until START or STOP
// RULE20 - Any START or STOP resets bit and byte tracking
`include "lds_regs.svh"
module lds_i2c_slave
	import lds_pkg::*;
#(
	parameter int TOUT_CYC = (`LDS_TOUT_MS * `LDS_NS_PER_MS)
	                         / `LDS_CLK_PERIOD_NS
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       en_i,
	input  wire logic       overtemp_i,
	input  wire logic       timeout_en_i,
	input  wire logic       fault_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	output logic            fault_alert_out_n_o,
	output logic            fault_alert_out_n_oe_o,
	output logic [7:0]      reg_raddr_o,
	input  wire logic [7:0] reg_rdata_i,
	output logic            reg_rd_o,
	output logic [7:0]      reg_waddr_o,
	output logic [7:0]      reg_wdata_o,
	output logic            reg_we_o,
	output logic            reg_clear_o
);
	localparam int TW = $clog2(TOUT_CYC + 1);

	// A timeout shorter than one cycle could never be counted
	if (TOUT_CYC < 1) begin : g_tout_chk
		$error("TOUT_CYC must be at least one cycle");
	end

	// Line synchronisers and filters
	logic [2:0] scl_sh_ff, nxt_scl_sh, sda_sh_ff, nxt_sda_sh;
	logic       scl_f_ff, nxt_scl_f, sda_f_ff, nxt_sda_f;
	logic       scl_p_ff, nxt_scl_p, sda_p_ff, nxt_sda_p;
	logic       scl_rise, scl_fall, start_det, stop_det;

	// Three stages; a level counts only once stages two and three agree,
	// which also rejects glitches shorter than a clock at fast-plus rates.
	// A hundred clocks per phase leave ample margin at 1 MHz bus clocks. RULE15
	always_comb begin
		nxt_scl_sh = {scl_sh_ff[1:0], scl_i}; // RULE7
		nxt_sda_sh = {sda_sh_ff[1:0], sda_i};
		nxt_scl_f  = (scl_sh_ff[1] == scl_sh_ff[2]) ? scl_sh_ff[2] : scl_f_ff;
		nxt_sda_f  = (sda_sh_ff[1] == sda_sh_ff[2]) ? sda_sh_ff[2] : sda_f_ff;
		nxt_scl_p  = scl_f_ff;
		nxt_sda_p  = sda_f_ff;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_sh_ff <= 3'h7;
			sda_sh_ff <= 3'h7;
			scl_f_ff  <= 1'b1;
			sda_f_ff  <= 1'b1;
			scl_p_ff  <= 1'b1;
			sda_p_ff  <= 1'b1;
		end else begin
			scl_sh_ff <= nxt_scl_sh;
			sda_sh_ff <= nxt_sda_sh;
			scl_f_ff  <= nxt_scl_f;
			sda_f_ff  <= nxt_sda_f;
			scl_p_ff  <= nxt_scl_p;
			sda_p_ff  <= nxt_sda_p;
		end
	end

	assign scl_rise  = scl_f_ff & ~scl_p_ff;
	assign scl_fall  = ~scl_f_ff & scl_p_ff;
	assign start_det = scl_f_ff & scl_p_ff & sda_p_ff & ~sda_f_ff; // RULE11
	assign stop_det  = scl_f_ff & scl_p_ff & ~sda_p_ff & sda_f_ff; // RULE11

	// Stuck-bus timeout
	logic [TW-1:0] tout_ff, nxt_tout;
	logic          tout_hit, port_off;

	assign port_off = ~en_i | overtemp_i;
	assign tout_hit = (tout_ff == TW'(TOUT_CYC));

	always_comb begin
		nxt_tout = '0;
		if (timeout_en_i && !port_off && (!scl_f_ff || !sda_f_ff)) begin // RULE9
			nxt_tout = tout_hit ? tout_ff : tout_ff + TW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			tout_ff <= '0;
		else
			tout_ff <= nxt_tout;
	end

	function automatic logic [7:0] ptr_inc(input logic [7:0] p);
		ptr_inc = p + 8'h01;
	endfunction

	// Protocol engine
	lds_state_e state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr, wa_ff, nxt_wa, wd_ff, nxt_wd;
	logic       oe_ff, nxt_oe, rw_ff, nxt_rw, pset_ff, nxt_pset;
	logic       we_ff, nxt_we, rd_ff, nxt_rd, clr_ff, nxt_clr;
	logic       flt_ff, nxt_flt;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_sh    = sh_ff;
		nxt_ptr   = ptr_ff;
		nxt_wa    = wa_ff;
		nxt_wd    = wd_ff;
		nxt_oe    = oe_ff;
		nxt_rw    = rw_ff;
		nxt_pset  = pset_ff;
		nxt_we    = 1'b0;
		nxt_rd    = 1'b0;
		nxt_clr   = port_off; // RULE1
		nxt_flt   = fault_i; // RULE16
		if (port_off) begin // RULE2
			nxt_state = LDS_IDLE;
			nxt_oe    = 1'b0;
			nxt_cnt   = `LDS_CNT_RST;
			nxt_ptr   = `LDS_PTR_RST;
			nxt_pset  = 1'b0;
		end else if (tout_hit) begin // RULE9
			nxt_state = LDS_IDLE;
			nxt_oe    = 1'b0;
			nxt_cnt   = `LDS_CNT_RST;
		end else if (stop_det) begin // RULE20
			nxt_state = LDS_IDLE;
			nxt_oe    = 1'b0;
			nxt_cnt   = `LDS_CNT_RST;
			nxt_pset  = 1'b0;
		end else if (start_det) begin // RULE20
			nxt_state = LDS_ADDR;
			nxt_oe    = 1'b0;
			nxt_cnt   = `LDS_CNT_RST;
			nxt_pset  = 1'b0;
		end else begin
			case (state_ff)
				LDS_ADDR, LDS_WR: begin // RULE8
					if (scl_rise && cnt_ff != `LDS_BYTE_BITS) begin
						nxt_sh  = {sh_ff[6:0], sda_f_ff};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == `LDS_BYTE_BITS) begin
						nxt_cnt = `LDS_CNT_RST;
						if (state_ff == LDS_WR) begin
							nxt_state = LDS_ACK_W;
							nxt_oe    = 1'b1; // RULE12
							if (!pset_ff) begin // RULE17
								nxt_ptr  = sh_ff;
								nxt_pset = 1'b1;
							end else begin // RULE17
								nxt_we  = 1'b1;
								nxt_wa  = ptr_ff;
								nxt_wd  = sh_ff;
								nxt_ptr = ptr_inc(ptr_ff);
							end
						end else if (sh_ff[7:1] == `LDS_SLV_ADDR) begin // RULE13
							nxt_state = LDS_ACK_A;
							nxt_oe    = 1'b1; // RULE12
							nxt_rw    = sh_ff[0]; // RULE14
						end else begin
							nxt_state = LDS_IGNORE; // RULE19
						end
					end
				end
				LDS_ACK_A: begin
					if (scl_fall) begin
						nxt_cnt = `LDS_CNT_RST;
						if (rw_ff == `LDS_RW_READ) begin // RULE18
							nxt_state = LDS_RD;
							nxt_sh    = reg_rdata_i;
							nxt_oe    = ~reg_rdata_i[7]; // RULE6
							nxt_rd    = 1'b1;
						end else begin
							nxt_state = LDS_WR;
							nxt_oe    = 1'b0;
						end
					end
				end
				LDS_ACK_W: begin
					if (scl_fall) begin
						nxt_state = LDS_WR;
						nxt_oe    = 1'b0;
					end
				end
				LDS_RD: begin
					if (scl_fall) begin
						if (cnt_ff == `LDS_LAST_BIT) begin
							nxt_state = LDS_ACK_R;
							nxt_oe    = 1'b0;
							nxt_cnt   = `LDS_CNT_RST;
						end else begin
							nxt_sh  = {sh_ff[6:0], 1'b0};
							nxt_oe  = ~sh_ff[6]; // RULE6
							nxt_cnt = cnt_ff + 4'h1;
						end
					end
				end
				LDS_ACK_R: begin
					if (scl_rise) begin
						if (!sda_f_ff)
							nxt_ptr = ptr_inc(ptr_ff); // RULE18
						else
							nxt_state = LDS_IGNORE; // RULE18
					end else if (scl_fall) begin
						nxt_state = LDS_RD;
						nxt_sh    = reg_rdata_i;
						nxt_oe    = ~reg_rdata_i[7];
						nxt_rd    = 1'b1;
					end
				end
				LDS_IDLE, LDS_IGNORE: begin
					nxt_oe = 1'b0;
				end
				default: begin
					nxt_state = LDS_IDLE;
					nxt_oe    = 1'b0;
				end
			endcase
		end
	end

	// Reset values are the defaults the driver runs on without any access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin // RULE4
			state_ff <= LDS_IDLE;
			cnt_ff   <= `LDS_CNT_RST;
			sh_ff    <= `LDS_BYTE_RST;
			ptr_ff   <= `LDS_PTR_RST;
			wa_ff    <= `LDS_PTR_RST;
			wd_ff    <= `LDS_BYTE_RST;
			oe_ff    <= 1'b0;
			rw_ff    <= 1'b0;
			pset_ff  <= 1'b0;
			we_ff    <= 1'b0;
			rd_ff    <= 1'b0;
			clr_ff   <= 1'b1;
			flt_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			sh_ff    <= nxt_sh;
			ptr_ff   <= nxt_ptr;
			wa_ff    <= nxt_wa;
			wd_ff    <= nxt_wd;
			oe_ff    <= nxt_oe;
			rw_ff    <= nxt_rw;
			pset_ff  <= nxt_pset;
			we_ff    <= nxt_we;
			rd_ff    <= nxt_rd;
			clr_ff   <= nxt_clr;
			flt_ff   <= nxt_flt;
		end
	end

	// Open drain: the pin level is only ever pulled low, never driven high
	assign sda_o                  = 1'b0; // RULE6
	assign sda_oe_o               = oe_ff;
	assign fault_alert_out_n_o    = 1'b0;
	assign fault_alert_out_n_oe_o = flt_ff; // RULE16
	assign reg_raddr_o            = ptr_ff;
	assign reg_rd_o               = rd_ff;
	assign reg_waddr_o            = wa_ff;
	assign reg_wdata_o            = wd_ff;
	assign reg_we_o               = we_ff;
	assign reg_clear_o            = clr_ff;

	property p_ot_idle;
		@(posedge clk_i) disable iff (rst_i)
		overtemp_i |=> (state_ff == LDS_IDLE) && !sda_oe_o && reg_clear_o;
	endproperty
	a_ot_idle: assert property (p_ot_idle) // RULE2
		else $error("over-temperature did not disable port");

	property p_clear;
		@(posedge clk_i) disable iff (rst_i)
		!en_i |=> reg_clear_o && (reg_raddr_o == `LDS_PTR_RST);
	endproperty
	a_clear: assert property (p_clear) // RULE1
		else $error("disable did not clear registers");

	property p_start;
		@(posedge clk_i) disable iff (rst_i)
		(start_det && !port_off && !tout_hit && !stop_det)
			|=> (state_ff == LDS_ADDR) && (cnt_ff == `LDS_CNT_RST) && !sda_oe_o;
	endproperty
	a_start: assert property (p_start) // RULE20
		else $error("START did not restart byte tracking");

	property p_stop;
		@(posedge clk_i) disable iff (rst_i)
		stop_det |=> (state_ff == LDS_IDLE) && !sda_oe_o;
	endproperty
	a_stop: assert property (p_stop) // RULE11
		else $error("STOP did not return to idle");

	property p_nomatch;
		@(posedge clk_i) disable iff (rst_i)
		(state_ff == LDS_ADDR && scl_fall && cnt_ff == `LDS_BYTE_BITS
		 && sh_ff[7:1] != `LDS_SLV_ADDR && !port_off && !tout_hit
		 && !start_det && !stop_det)
			|=> (state_ff == LDS_IGNORE) && !sda_oe_o;
	endproperty
	a_nomatch: assert property (p_nomatch) // RULE19
		else $error("foreign address acknowledged");

	property p_ack_addr;
		@(posedge clk_i) disable iff (rst_i)
		$rose(state_ff == LDS_ACK_A) |-> sda_oe_o && ($past(sh_ff[7:1])
			== `LDS_SLV_ADDR);
	endproperty
	a_ack_addr: assert property (p_ack_addr) // RULE13
		else $error("address ack without match");

	property p_ack_low;
		@(posedge clk_i) disable iff (rst_i)
		(state_ff == LDS_ACK_W || state_ff == LDS_ACK_A) |-> sda_oe_o;
	endproperty
	a_ack_low: assert property (p_ack_low) // RULE12
		else $error("data line not held low during ack");

	property p_tout;
		@(posedge clk_i) disable iff (rst_i)
		tout_hit |=> (state_ff == LDS_IDLE) && !sda_oe_o;
	endproperty
	a_tout: assert property (p_tout) // RULE9
		else $error("stuck bus not released");

	property p_wr_inc;
		@(posedge clk_i) disable iff (rst_i)
		reg_we_o |-> (reg_raddr_o == ptr_inc(reg_waddr_o));
	endproperty
	a_wr_inc: assert property (p_wr_inc) // RULE17
		else $error("pointer not incremented after write");

	property p_rd_end;
		@(posedge clk_i) disable iff (rst_i)
		(state_ff == LDS_ACK_R) |-> !sda_oe_o;
	endproperty
	a_rd_end: assert property (p_rd_end) // RULE18
		else $error("data line driven during master ack");

	c_start: cover property (@(posedge clk_i) disable iff (rst_i) start_det);
	c_write: cover property (@(posedge clk_i) disable iff (rst_i) reg_we_o);
	c_read:  cover property (@(posedge clk_i) disable iff (rst_i)
		state_ff == LDS_ACK_R ##1 state_ff == LDS_RD);
	c_tout:  cover property (@(posedge clk_i) disable iff (rst_i) tout_hit);
endmodule

// ===== logic/lds_regs.svh
// Constants of the LED driver serial slave port
`ifndef LDS_REGS_SVH
`define LDS_REGS_SVH
`define LDS_SLV_ADDR      7'h50
`define LDS_RW_READ       1'b1
`define LDS_BYTE_BITS     4'h8
`define LDS_LAST_BIT      4'h7
`define LDS_CNT_RST       4'h0
`define LDS_PTR_RST       8'h00
`define LDS_BYTE_RST      8'h00
`define LDS_CLK_PERIOD_NS 5
`define LDS_TOUT_MS       30
`define LDS_NS_PER_MS     1000000
`endif

// ===== logic/lds_pkg.sv
// Types of the LED driver serial slave port
package lds_pkg;
	typedef enum logic [2:0] {
		LDS_IDLE   = 3'h0,
		LDS_ADDR   = 3'h1,
		LDS_ACK_A  = 3'h3,
		LDS_WR     = 3'h2,
		LDS_ACK_W  = 3'h6,
		LDS_RD     = 3'h7,
		LDS_ACK_R  = 3'h5,
		LDS_IGNORE = 3'h4
	} lds_state_e;
endpackage

// ===== testbench/lds_i2c_master_model.sv
// Behavioural bus master that drives the serial link for the bench
module lds_i2c_master_model (
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 32;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Only the master moves the clock; the clock stands high between frames
	task automatic start();
		#8 sda_o = 1'b1;
		#HALF scl_o = 1'b1;
		#HALF sda_o = 1'b0;
		#HALF scl_o = 1'b0;
	endtask
	task automatic stop();
		#8 sda_o = 1'b0;
		#HALF scl_o = 1'b1;
		#HALF sda_o = 1'b1;
		#HALF;
	endtask
	// Data moves a little after the clock fell, so a fall is never a START
	task automatic bit_x(input logic b, output logic r);
		#8 sda_o = b;
		#(HALF - 8) scl_o = 1'b1;
		#(HALF / 2) r = sda_i;
		#(HALF / 2) scl_o = 1'b0;
	endtask
	// Nine clocks a byte, MSB first; ack_in low acknowledges a read byte
	task automatic byte_x(input logic [7:0] d, input logic ack_in,
		output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r[i]);
		bit_x(ack_in, ack);
	endtask
endmodule

// ===== testbench/test_lds_i2c_slave.sv
// Self-checking bench of the serial slave port with a bus master model
module test_lds_i2c_slave;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TOUT = 200;
	logic       clk_i, rst_i, en_i, overtemp_i, timeout_en_i, fault_i;
	logic       m_scl, m_sda, sda_i, sda_o, sda_oe_o;
	logic       fault_alert_out_n_o, fault_alert_out_n_oe_o;
	logic [7:0] reg_raddr_o, reg_rdata_i, reg_waddr_o, reg_wdata_o;
	logic       reg_rd_o, reg_we_o, reg_clear_o;
	logic [7:0] mem [256];
	int         writes, reads, failures, checked;

	lds_i2c_slave #(.TOUT_CYC(TOUT)) u_lds_i2c_slave (
		.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .overtemp_i(overtemp_i),
		.timeout_en_i(timeout_en_i), .fault_i(fault_i), .scl_i(m_scl),
		.sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.fault_alert_out_n_o(fault_alert_out_n_o),
		.fault_alert_out_n_oe_o(fault_alert_out_n_oe_o),
		.reg_raddr_o(reg_raddr_o), .reg_rdata_i(reg_rdata_i),
		.reg_rd_o(reg_rd_o), .reg_waddr_o(reg_waddr_o),
		.reg_wdata_o(reg_wdata_o), .reg_we_o(reg_we_o),
		.reg_clear_o(reg_clear_o));
	lds_i2c_master_model u_lds_i2c_master_model (
		.sda_i(sda_i), .scl_o(m_scl), .sda_o(m_sda));

	// Wired data line with pull-up: low if either party pulls it
	assign sda_i = m_sda & ~(sda_oe_o & ~sda_o);
	assign reg_rdata_i = mem[reg_raddr_o];
	always @(posedge clk_i) begin
		if (reg_clear_o)
			mem <= '{default: 8'h00};
		else if (reg_we_o) begin
			mem[reg_waddr_o] <= reg_wdata_o;
			writes <= writes + 1;
		end
	end

	always @(posedge clk_i) begin
		if (reg_rd_o)
			reads <= reads + 1;
	end

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [7:0] d, input logic exp_ack);
		logic [7:0] r;
		logic       a;
		u_lds_i2c_master_model.byte_x(d, 1'b1, r, a);
		chk(8'(a), 8'(exp_ack));
	endtask

	task automatic t_fault();
		@(negedge clk_i) fault_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1 chk(8'(fault_alert_out_n_oe_o), 8'h01);
		chk(8'(fault_alert_out_n_o), 8'h00);
		chk(8'(sda_o), 8'h00);
		@(negedge clk_i) fault_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1 chk(8'(fault_alert_out_n_oe_o), 8'h00);
	endtask

	task automatic t_write();
		int n;
		n = writes;
		u_lds_i2c_master_model.start();
		wr(8'ha0, 1'b0);
		wr(8'h10, 1'b0);
		u_lds_i2c_master_model.stop();
		chk(reg_raddr_o, 8'h10);
		chk(8'(writes - n), 8'h00);
		u_lds_i2c_master_model.start();
		wr(8'ha0, 1'b0);
		wr(8'h05, 1'b0);
		wr(8'h3c, 1'b0);
		wr(8'h7e, 1'b0);
		u_lds_i2c_master_model.stop();
		chk(mem[5], 8'h3c);
		chk(mem[6], 8'h7e);
		chk(reg_raddr_o, 8'h07);
	endtask

	task automatic t_read();
		logic [7:0] r;
		logic       a;
		int         n;
		n = reads;
		u_lds_i2c_master_model.start();
		wr(8'ha0, 1'b0);
		wr(8'h05, 1'b0);
		u_lds_i2c_master_model.start();
		wr(8'ha1, 1'b0);
		u_lds_i2c_master_model.byte_x(8'hff, 1'b0, r, a);
		chk(r, 8'h3c);
		u_lds_i2c_master_model.byte_x(8'hff, 1'b1, r, a);
		chk(r, 8'h7e);
		u_lds_i2c_master_model.stop();
		chk(reg_raddr_o, 8'h06);
		chk(8'(reads - n), 8'h02);
	endtask

	task automatic t_wrong();
		int n;
		n = writes;
		u_lds_i2c_master_model.start();
		wr(8'ha2, 1'b1);
		wr(8'h55, 1'b1);
		wr(8'h66, 1'b1);
		u_lds_i2c_master_model.stop();
		chk(8'(writes - n), 8'h00);
	endtask

	task automatic t_off();
		int n;
		for (int k = 0; k < 2; k++) begin
			n = writes;
			@(negedge clk_i);
			if (k == 0)
				en_i = 1'b0;
			else
				overtemp_i = 1'b1;
			repeat (3) @(posedge clk_i);
			#1 chk(8'(reg_clear_o), 8'h01);
			chk(reg_raddr_o, 8'h00);
			u_lds_i2c_master_model.start();
			wr(8'ha0, 1'b1);
			wr(8'h33, 1'b1);
			u_lds_i2c_master_model.stop();
			chk(8'(writes - n), 8'h00);
			@(negedge clk_i) en_i = 1'b1;
			overtemp_i = 1'b0;
		end
		// Settings are lost at turn-off, so the host loads them again
		u_lds_i2c_master_model.start();
		wr(8'ha0, 1'b0);
		wr(8'h05, 1'b0);
		wr(8'h3c, 1'b0);
		u_lds_i2c_master_model.stop();
		chk(mem[5], 8'h3c);
	endtask

	task automatic t_timeout();
		logic r;
		u_lds_i2c_master_model.start();
		for (int i = 7; i >= 0; i--)
			u_lds_i2c_master_model.bit_x(1'(8'ha0 >> i), r);
		#40 chk(8'(sda_oe_o), 8'h01);
		#1200 chk(8'(sda_oe_o), 8'h01);
		@(negedge clk_i) timeout_en_i = 1'b1;
		#1200 chk(8'(sda_oe_o), 8'h00);
		u_lds_i2c_master_model.start();
		wr(8'ha0, 1'b0);
		u_lds_i2c_master_model.stop();
		@(negedge clk_i) timeout_en_i = 1'b0;
	endtask

	initial begin
		rst_i = 1'b1;
		en_i = 1'b1;
		overtemp_i = 1'b0;
		timeout_en_i = 1'b0;
		fault_i = 1'b0;
		writes = 0;
		reads = 0;
		failures = 0;
		checked = 0;
		repeat (12) @(posedge clk_i);
		@(negedge clk_i) rst_i = 1'b0;
		repeat (8) @(posedge clk_i);
		t_fault();
		t_write();
		t_read();
		t_wrong();
		t_off();
		t_timeout();
		report_and_stop();
	end

	// Whole run needs well under half of this span
	initial begin
		#100000;
		failures++;
		report_and_stop();
	end
endmodule
